// *** dv/accel_reset_fault_supervisor_bench.sv ***
// scenario bench for the supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module accel_reset_fault_supervisor_bench;
    logic clk_sys_in = 0, arst_n_in = 0, supply_above_trip_in = 0, overload_in = 0;
    logic rst_drive = 0, st_drive = 0, ext_reset_n_in, self_check_enable_in;
    logic supply_ok_out, fault_out, startup_done_out;
    logic [11:0] accel_code_in = 12'h800, positive_analog_out, negative_analog_out, p;
    int compares = 0, miscompares = 0, n;
    always #4 clk_sys_in = ~clk_sys_in;
    host_pads pads_u (.rst_drive_in(rst_drive), .st_drive_in(st_drive),
        .ext_reset_n_out(ext_reset_n_in), .self_check_out(self_check_enable_in));
    accel_reset_fault_supervisor #(.STARTUP_CYCLES(20), .HALF_CYCLES(8)) dut_u (.*);
    task conclude;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task step(input int k);
        repeat (k) @(posedge clk_sys_in);
        #1;
    endtask
    // 2 sync edges + 1 to START + 20 startup + 1
    task run_up;
        n = 0;
        while (startup_done_out !== 1'b1) begin
            step(1);
            n++;
            if (n > 99) begin miscompares++; conclude(); end
        end
        `CHK("len", 1'b1, n >= 22 && n <= 26)
        `CHK("fault", 1'b0, fault_out)
    endtask
    task power_up;
        step(6);
        `CHK("ok", 1'b0, supply_ok_out)
        `CHK("fault", 1'b1, fault_out)
        supply_above_trip_in = 1;
        run_up;
    endtask
    // 0 reset, 1 overload, 2 supply drop
    task upset(input int c);
        accel_code_in = 12'h900;
        rst_drive = (c == 0);
        overload_in = (c == 1);
        supply_above_trip_in = (c != 2);
        step(40);
        `CHK("fault", 1'b1, fault_out)
        `CHK("run", 1'b0, startup_done_out)
        if (c == 0) `CHK("mid", 24'h800800, {positive_analog_out, negative_analog_out})
        if (c == 2) `CHK("ok", 1'b0, supply_ok_out)
        rst_drive = 0;
        overload_in = 0;
        supply_above_trip_in = 1;
        run_up;
        `CHK("out", 24'h900700, {positive_analog_out, negative_analog_out})
        accel_code_in = 12'h800;
        step(1);
    endtask
    task self_check;
        st_drive = 1;
        step(4);
        for (int i = 0; i < 2; i++) begin
            p = positive_analog_out;
            n = 0;
            while (positive_analog_out === p && n < 20) begin step(1); n++; end
        end
        `CHK("half", 8, n)
        `CHK("sum", 12'h000, p + positive_analog_out)
        st_drive = 0;
        step(4);
        `CHK("off", 12'h800, positive_analog_out)
    endtask
    initial begin
        step(2);
        arst_n_in = 1;
        power_up;
        self_check;
        for (int c = 0; c < 3; c++) upset(c);
        conclude;
    end
endmodule // accel_reset_fault_supervisor_bench
`default_nettype wire

// *** dv/host_pads.sv ***
// host side pads with pull-up on reset, pull-down on self-check
`timescale 1ns/1ps
`default_nettype none
module host_pads (
    // host drive controls
    input wire logic rst_drive_in,
    input wire logic st_drive_in,
    // pad levels
    output logic ext_reset_n_out,
    output logic self_check_out
);
    assign ext_reset_n_out = rst_drive_in ? 1'b0 : 1'b1;
    assign self_check_out = st_drive_in ? 1'b1 : 1'b0;
endmodule // host_pads
`default_nettype wire

// *** dv/supervisor_checker.sv ***
// assertions on the supervisor ports
`timescale 1ns/1ps
`default_nettype none
module supervisor_checker (
    // clock, reset and inputs
    input wire logic clk_sys_in,
    input wire logic arst_n_in,
    input wire logic supply_above_trip_in,
    input wire logic ext_reset_n_in,
    input wire logic self_check_enable_in,
    input wire logic overload_in,
    input wire logic [11:0] accel_code_in,
    // outputs
    input wire logic supply_ok_out,
    input wire logic fault_out,
    input wire logic startup_done_out,
    input wire logic [11:0] positive_analog_out,
    input wire logic [11:0] negative_analog_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    supply_low_a: assert property (!supply_above_trip_in [*4] |-> !supply_ok_out)
        else $error("supply ok while low");
    supply_rise_a: assert property (supply_above_trip_in [*4] |-> supply_ok_out)
        else $error("supply ok missing");
    fault_supply_a: assert property (!supply_ok_out [*2] |-> fault_out && !startup_done_out)
        else $error("no fault on supply");
    reset_mid_a: assert property (!ext_reset_n_in [*4] |-> fault_out &&
        {positive_analog_out, negative_analog_out} == 24'h800800) else $error("reset outputs");
    overload_a: assert property (overload_in [*4] |-> fault_out ##1 !startup_done_out)
        else $error("overload not flagged");
    run_fault_a: assert property ($rose(startup_done_out) |-> !fault_out)
        else $error("fault after startup");
    track_a: assert property ((ext_reset_n_in && !self_check_enable_in && !overload_in &&
        supply_above_trip_in && startup_done_out) [*4] |-> positive_analog_out ==
        $past(accel_code_in) && positive_analog_out + negative_analog_out == 12'h000)
        else $error("outputs not tracking");
    stim_a: assert property ((self_check_enable_in && startup_done_out) [*4] |->
        positive_analog_out - $past(accel_code_in) == 12'h070 ||
        positive_analog_out - $past(accel_code_in) == 12'hf90) else $error("stimulus step");
    run_c: cover property ($rose(startup_done_out));
    stim_c: cover property (self_check_enable_in && startup_done_out);
    ovl_c: cover property (overload_in && fault_out);
endmodule // supervisor_checker
bind accel_reset_fault_supervisor supervisor_checker chk_u (.*);
`default_nettype wire

// *** hdl/accel_reset_fault_supervisor.v ***
// supervisory logic: supply ok, reset, self-check stimulus and fault flag
// Functional notes
// - supply ok low until trip level reached
// - after supply drop, full new startup
// - fault flag high until startup completes
// - external reset active low, pulled up
// - reset forces outputs to mid, fault high
// - self-check active high, pulled down
// - self-check adds 24 Hz 1.3 g square
// - fault on supply, reset or overload
// - overload restarts startup until back in range
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_regs.vh"
module accel_reset_fault_supervisor #(
    parameter STARTUP_CYCLES = `STARTUP_CYCLES,
    parameter HALF_CYCLES = `SELF_CHECK_HALF_CYCLES,
    parameter OUT_WIDTH = `OUT_WIDTH
) (
    // clock and reset
    input wire clk_sys_in,
    input wire arst_n_in,
    // supply comparator: high while supply above supply_trip_level
    input wire supply_above_trip_in,
    // host pins; pull-up and pull-down are modelled by pad defaults
    input wire ext_reset_n_in,
    input wire self_check_enable_in,
    // overload comparator from the readout path
    input wire overload_in,
    // acceleration code from the readout path
    input wire [OUT_WIDTH-1:0] accel_code_in,
    // supervisor status
    output reg supply_ok_out,
    output reg fault_out,
    output reg startup_done_out,
    // analog output codes
    output reg [OUT_WIDTH-1:0] positive_analog_out,
    output reg [OUT_WIDTH-1:0] negative_analog_out
);
    localparam [2:0] ST_OFF = 3'b001;
    localparam [2:0] ST_START = 3'b010;
    localparam [2:0] ST_RUN = 3'b100;
    localparam CW = 32;
    // counter end points at counter width
    localparam [CW-1:0] START_LAST = STARTUP_CYCLES - 1;
    localparam [CW-1:0] WAVE_LAST = HALF_CYCLES - 1;

    wire supply_s;
    wire rst_n_s;
    wire self_check_s;
    wire overload_s;
    // pull-up on reset: idle state is high
    sync_two_ff #(.RESET_VALUE(1'b1)) u_sync_rst (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .async_in(ext_reset_n_in),
        .sync_out(rst_n_s)
    );
    // pull-down on self-check: idle state is low
    sync_two_ff #(.RESET_VALUE(1'b0)) u_sync_st (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .async_in(self_check_enable_in),
        .sync_out(self_check_s)
    );
    sync_two_ff #(.RESET_VALUE(1'b0)) u_sync_sup (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .async_in(supply_above_trip_in),
        .sync_out(supply_s)
    );
    sync_two_ff #(.RESET_VALUE(1'b0)) u_sync_ovl (
        .clk_sys_in(clk_sys_in),
        .arst_n_in(arst_n_in),
        .async_in(overload_in),
        .sync_out(overload_s)
    );

    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [CW-1:0] start_cnt_reg;
    reg [CW-1:0] start_cnt_next;
    reg [CW-1:0] wave_cnt_reg;
    reg wave_phase_reg;

    // counter end points and restart cause
    wire start_last = (start_cnt_reg >= START_LAST);
    wire wave_last = (wave_cnt_reg >= WAVE_LAST);
    wire start_hold = !rst_n_s || overload_s;

    // sequencer; any disturbance restarts startup from zero
    always @* begin
        state_next = state_reg;
        start_cnt_next = start_cnt_reg;
        case (state_reg)
            ST_OFF: begin
                start_cnt_next = {CW{1'b0}};
                if (supply_s) begin
                    state_next = ST_START;
                end
            end
            ST_START: begin
                if (!supply_s) begin
                    state_next = ST_OFF;
                end else if (start_hold) begin
                    start_cnt_next = {CW{1'b0}};
                end else if (start_last) begin
                    state_next = ST_RUN;
                end else begin
                    start_cnt_next = start_cnt_reg + 32'h1;
                end
            end
            ST_RUN: begin
                if (!supply_s) begin
                    state_next = ST_OFF;
                end else if (start_hold) begin
                    state_next = ST_START;
                    start_cnt_next = {CW{1'b0}};
                end
            end
            default: begin
                state_next = ST_OFF;
                start_cnt_next = {CW{1'b0}};
            end
        endcase
    end

    // sequencer state
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg <= ST_OFF;
        end else begin
            state_reg <= state_next;
        end
    end

    // startup counter; a hold keeps it at zero
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            start_cnt_reg <= {CW{1'b0}};
        end else begin
            start_cnt_reg <= start_cnt_next;
        end
    end

    // self-check square wave, 50 % duty
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wave_cnt_reg <= {CW{1'b0}};
            wave_phase_reg <= 1'b0;
        end else if (!self_check_s) begin
            wave_cnt_reg <= {CW{1'b0}};
            wave_phase_reg <= 1'b0;
        end else if (wave_last) begin
            wave_cnt_reg <= {CW{1'b0}};
            wave_phase_reg <= ~wave_phase_reg;
        end else begin
            wave_cnt_reg <= wave_cnt_reg + 32'h1;
        end
    end

    // output codes and flags
    wire [OUT_WIDTH-1:0] mid = `OUT_MID;
    wire [OUT_WIDTH-1:0] step = `SELF_CHECK_STEP;
    wire [OUT_WIDTH-1:0] step_neg = ~step + {{(OUT_WIDTH-1){1'b0}}, 1'b1};
    wire [OUT_WIDTH-1:0] half_diff = accel_code_in - mid;
    wire [OUT_WIDTH-1:0] stim = self_check_s ? (wave_phase_reg ? step : step_neg)
                                             : {OUT_WIDTH{1'b0}};
    wire [OUT_WIDTH-1:0] diff = half_diff + stim;
    wire running = (state_reg == ST_RUN);

    // fault causes; any one marks the outputs invalid
    wire cause_startup = !running;
    wire cause_supply = !supply_s;
    wire cause_reset = !rst_n_s;
    wire cause_overload = overload_s;
    wire any_cause = cause_startup || cause_supply || cause_reset || cause_overload;

    // next values of the registered outputs
    reg supply_ok_next;
    reg fault_next;
    reg startup_done_next;
    reg [OUT_WIDTH-1:0] positive_next;
    reg [OUT_WIDTH-1:0] negative_next;

    always @* begin
        supply_ok_next = supply_s;
        fault_next = any_cause;
        startup_done_next = running;
        if (cause_reset) begin
            // outputs parked at half supply
            positive_next = mid;
            negative_next = mid;
        end else begin
            positive_next = mid + diff;
            negative_next = mid - diff;
        end
    end

    // status flags
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            supply_ok_out <= `SUPPLY_OK_RESET;
            fault_out <= `FAULT_RESET;
            startup_done_out <= `STARTUP_DONE_RESET;
        end else begin
            supply_ok_out <= supply_ok_next;
            fault_out <= fault_next;
            startup_done_out <= startup_done_next;
        end
    end

    // analog output codes
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            positive_analog_out <= `OUT_MID;
            negative_analog_out <= `OUT_MID;
        end else begin
            positive_analog_out <= positive_next;
            negative_analog_out <= negative_next;
        end
    end
endmodule // accel_reset_fault_supervisor
`default_nettype wire

// *** hdl/sync_two_ff.v ***
// two flip-flop synchroniser for one level input
`timescale 1ns/1ps
`default_nettype none
module sync_two_ff #(
    parameter RESET_VALUE = 1'b0
) (
    // clock and reset
    input wire clk_sys_in,
    input wire arst_n_in,
    // level in and out
    input wire async_in,
    output wire sync_out
);
    reg meta_reg;
    reg sync_reg;
    always @(posedge clk_sys_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            meta_reg <= RESET_VALUE;
            sync_reg <= RESET_VALUE;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end
    assign sync_out = sync_reg;
endmodule // sync_two_ff
`default_nettype wire

// *** pkg/supervisor_regs.vh ***
// timing constants for the accelerometer reset and fault supervisor
`ifndef SUPERVISOR_REGS_VH
`define SUPERVISOR_REGS_VH
`define CLK_HZ 125000000
// startup sequence length in microseconds
`define STARTUP_US 1000
`define STARTUP_CYCLES ((`CLK_HZ / 1000000) * `STARTUP_US)
// self-check square wave, tenths of hertz (24.4 Hz)
`define SELF_CHECK_DHZ 244
`define SELF_CHECK_HALF_CYCLES ((`CLK_HZ * 10) / (2 * `SELF_CHECK_DHZ))
// analog output codes (unsigned, mid scale is half supply)
`define OUT_WIDTH 12
`define OUT_MID 12'h800
// self-check step, 0.65 g each side of mid, as a code
`define SELF_CHECK_STEP 12'h070
// status flag reset values
`define SUPPLY_OK_RESET 1'b0
`define FAULT_RESET 1'b1
`define STARTUP_DONE_RESET 1'b0
`endif
